// ### sim/tb.sv
// Self-checking bench for the UART interrupt and FIFO control block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_ifc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, soft_rst = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, div_low, div_high, tx_byte, v;
  logic irq_pending, fifo_en, tx_fifo_clear, rx_fifo_clear, tx_load;
  logic osc_stop, modem_toggle, rx_pin;
  logic [6:0] rx_count, tx_count;
  int_src_s int_src;
  logic [6:0] rt [4] = '{RX_TRIG_00, RX_TRIG_01, RX_TRIG_10, RX_TRIG_11};
  logic [6:0] tt [4] = '{TX_TRIG_00, TX_TRIG_01, TX_TRIG_10, TX_TRIG_11};
  int bad_count = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  uart_int_fifo_ctl uut (.*);
  uart_far_model pm (.*);
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // The read starts a cycle later, so the identification register has caught up.
  task step(input logic [6:0] s, rc, tc, input logic [7:0] e);
    pm.int_src = s;
    pm.rx_count = rc;
    pm.tx_count = tc;
    rd(4'h2, v);
    chk(v, e); // identification value
    chk(irq_pending, e[0] ? 8'h00 : 8'h01); // pending output
  endtask
  task enh(input logic [7:0] e);
    wr(4'h3, LCR_ENH_KEY);
    wr(4'h2, e);
    wr(4'h3, 8'h00);
  endtask
  task t_div;
    rd(4'h1, v);
    chk(v, IER_RST); // enable reset value
    rd(4'h2, v);
    chk(v, IIR_RST); // idle code
    wr(4'h3, 8'h80);
    wr(4'h0, 8'h12);
    wr(4'h1, 8'h34);
    rd(4'h1, v);
    chk(v, 8'h34); // high byte readback
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    chk(div_low, 8'h12); // low byte kept
    chk(div_high, 8'h34); // high byte kept
  endtask
  task t_lock;
    wr(4'h1, 8'hFF);
    rd(4'h1, v);
    chk(v, 8'h0F); // upper bits locked
    enh(8'h10);
    wr(4'h1, 8'hFF);
    rd(4'h1, v);
    chk(v, 8'hFF); // upper bits unlocked
  endtask
  task t_prio;
    step(7'h7F, 7'h01, 7'h00, 8'h06); // line first
    step(7'h3F, 7'h01, 7'h00, 8'h0C); // timeout
    step(7'h1F, 7'h01, 7'h00, 8'h04); // receive ready
    step(7'h1F, 7'h00, 7'h00, 8'h02); // holding empty
    step(7'h1F, 7'h00, 7'h01, 8'h00); // modem
    step(7'h0F, 7'h00, 7'h01, 8'h30); // gpio
    step(7'h0E, 7'h00, 7'h01, 8'h10); // xoff
    step(7'h0C, 7'h00, 7'h01, 8'h20); // cts change
    step(7'h04, 7'h00, 7'h01, 8'h20); // rts change
    step(7'h00, 7'h00, 7'h01, 8'h01); // none pending
    wr(4'h1, 8'h00);
    step(7'h7F, 7'h01, 7'h01, 8'h30); // sources gated, gpio ungated
  endtask
  task t_trig;
    wr(4'h1, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(4'h2, {i[1:0], i[1:0], 4'h1});
      step(7'h00, rt[i] - 7'h01, FIFO_DEPTH, 8'hC1); // below
      step(7'h00, rt[i], FIFO_DEPTH, 8'hC4); // at level
      step(7'h00, 7'h00, FIFO_DEPTH - tt[i], 8'hC1); // equal
      step(7'h00, 7'h00, FIFO_DEPTH - tt[i] - 7'h01, 8'hC2); // above
    end
    enh(8'h00);
    wr(4'h2, 8'h01);
    step(7'h00, 7'h00, 7'h08, 8'hC1); // field held
  endtask
  task t_clear;
    wr(4'h2, 8'h07);
    chk({tx_fifo_clear, rx_fifo_clear}, 2'b11); // clear pulses
    @(negedge clk);
    chk({tx_fifo_clear, rx_fifo_clear}, 2'b00); // self clearing
    wr(4'h2, 8'h06);
    chk({tx_fifo_clear, rx_fifo_clear, fifo_en}, 3'b000); // locked
    step(7'h00, 7'h00, 7'h00, 8'h02); // mirror off
  endtask
  task t_sleep;
    enh(8'h10);
    wr(4'h1, 8'hF0);
    repeat (4) @(negedge clk);
    chk(osc_stop, 1'b1); // idle entry
    pm.modem_toggle = 1'b1;
    repeat (2) @(negedge clk);
    chk(osc_stop, 1'b0); // modem wake
    pm.modem_toggle = 1'b0;
    repeat (4) @(negedge clk);
    chk(osc_stop, 1'b1); // stopped again
    pm.rx_pin = 1'b0;
    repeat (2) @(negedge clk);
    chk(osc_stop, 1'b0); // rx wake
    pm.rx_pin = 1'b1;
    repeat (4) @(negedge clk);
    wr(4'h0, 8'hA5);
    chk(tx_byte, 8'hA5); // holding data
    chk({tx_load, osc_stop}, 2'b10); // load wake
  endtask
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    t_div;
    t_lock;
    t_prio;
    t_trig;
    t_clear;
    t_sleep;
    conclude;
  end
  // Generous bound: the whole sequence needs about 150 cycles.
  initial begin
    #100000;
    bad_count++;
    conclude;
  end
endmodule

// ### sim/uart_far_model.sv
// Behavioural serial datapath model feeding the control block.
module uart_far_model (
  input wire logic clk,
  input wire logic tx_load,
  input wire logic tx_fifo_clear,
  input wire logic rx_fifo_clear,
  output uart_ifc_pkg::int_src_s int_src = '0,
  output logic [6:0] rx_count = 7'h00,
  output logic [6:0] tx_count = 7'h00,
  output logic modem_toggle = 1'b0,
  output logic rx_pin = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (tx_fifo_clear)
      tx_count <= 7'h00;
    else if (tx_load && tx_count < 7'h40)
      tx_count <= tx_count + 7'h01;
    if (rx_fifo_clear)
      rx_count <= 7'h00;
  end
endmodule

// ### sim/uart_ifc_monitor.sv
// Port-level concurrent checks for the interrupt and FIFO control block.
module uart_ifc_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [6:0] rx_count,
  input wire logic [6:0] tx_count,
  input wire logic modem_toggle,
  input wire logic rx_pin,
  input wire logic irq_pending,
  input wire logic [7:0] div_low,
  input wire logic [7:0] div_high,
  input wire logic fifo_en,
  input wire logic tx_fifo_clear,
  input wire logic rx_fifo_clear,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  input wire logic osc_stop
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Any of these at the entry edge must keep the oscillator running.
  sequence s_restless;
    rx_count != 7'h00 || tx_count != 7'h00 || !rx_pin || modem_toggle ||
      irq_pending;
  endsequence
  property p_wake(logic cause);
    osc_stop && cause |=> !osc_stop;
  endproperty
  chk_sleep_entry: assert property (not (s_restless ##1 $rose(osc_stop)))
    else $error("sleep entered while busy");
  chk_wake_modem: assert property (p_wake(modem_toggle))
    else $error("no wake on modem toggle");
  chk_wake_rx: assert property (p_wake(!rx_pin))
    else $error("no wake on rx low");
  chk_load_wakes: assert property (tx_load |-> !osc_stop &&
    $past(reg_wr && reg_addr == 4'h0) && tx_byte == $past(reg_wdata))
    else $error("holding load wrong");
  chk_txclr_cause: assert property (tx_fifo_clear |->
    $past(reg_wr && reg_addr == 4'h2 && reg_wdata[2] && reg_wdata[0]))
    else $error("tx clear without write");
  chk_rxclr_cause: assert property (rx_fifo_clear |->
    $past(reg_wr && reg_addr == 4'h2 && reg_wdata[1] && reg_wdata[0]))
    else $error("rx clear without write");
  chk_clr_needs_fifo: assert property ((tx_fifo_clear || rx_fifo_clear) |-> fifo_en)
    else $error("clear with fifo off");
  chk_div_soft: assert property (soft_rst |=> $stable(div_low) && $stable(div_high))
    else $error("divisor lost on soft reset");
endmodule

bind uart_int_fifo_ctl uart_ifc_monitor mon (.*);

// ### verilog/int_prio_enc.sv
// Priority encoder for the interrupt identification code.
module int_prio_enc (
  input wire uart_ifc_pkg::int_req_s req,
  input wire logic enh_en,
  output logic [5:0] code
);
  import uart_ifc_pkg::*;

  always_comb begin
    code = IID_NONE;
    if (req.line) begin
      code = IID_LINE;
    end else if (req.rx_timeout) begin
      code = IID_RX_TIMEOUT;
    end else if (req.rx_ready) begin
      code = IID_RX_READY;
    end else if (req.tx_ready) begin
      code = IID_TX_READY;
    end else if (req.modem) begin
      code = IID_MODEM;
    // Codes using bits 5:4 need enhanced enable.
    end else if (enh_en && req.gpio) begin
      code = IID_GPIO;
    end else if (enh_en && req.xoff) begin
      code = IID_XOFF;
    end else if (enh_en && req.flow) begin
      code = IID_FLOW;
    end
  end

endmodule

// ### verilog/uart_ifc_pkg.sv
// Constants, carrier structs and reset values for the UART interrupt/FIFO control.
package uart_ifc_pkg;

  // Register offsets on the internal register port.
  localparam logic [3:0] OFS_HOLD = 4'h0;
  localparam logic [3:0] OFS_IER = 4'h1;
  localparam logic [3:0] OFS_IIR_FCR = 4'h2;
  localparam logic [3:0] OFS_LCR = 4'h3;

  // Bank select values of the line control register.
  localparam int LCR_DIV_BIT = 7;
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF;

  // Reset values.
  localparam logic [7:0] LCR_RST = 8'h1D;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] IIR_RST = 8'h01;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [7:0] DIV_LOW_RST = 8'h01;
  localparam logic [7:0] DIV_HIGH_RST = 8'h00;

  // Field positions.
  localparam int IER_CTS_DSR = 7;
  localparam int IER_RTS_DTR = 6;
  localparam int IER_XOFF = 5;
  localparam int IER_SLEEP = 4;
  localparam int IER_MODEM = 3;
  localparam int IER_LINE = 2;
  localparam int IER_TXRDY = 1;
  localparam int IER_RXRDY = 0;
  localparam int EFR_ENH = 4;
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_RX_CLR = 1;
  localparam int FCR_TX_CLR = 2;
  localparam int FCR_TX_TRIG_LO = 4;
  localparam int FCR_RX_TRIG_LO = 6;

  // Six-bit interrupt identification codes: none pending, then highest priority first.
  localparam logic [5:0] IID_NONE = 6'h01;
  localparam logic [5:0] IID_LINE = 6'h06;
  localparam logic [5:0] IID_RX_TIMEOUT = 6'h0C;
  localparam logic [5:0] IID_RX_READY = 6'h04;
  localparam logic [5:0] IID_TX_READY = 6'h02;
  localparam logic [5:0] IID_MODEM = 6'h00;
  localparam logic [5:0] IID_GPIO = 6'h30;
  localparam logic [5:0] IID_XOFF = 6'h10;
  localparam logic [5:0] IID_FLOW = 6'h20;

  // Trigger levels, indexed by the two-bit field code.
  localparam logic [6:0] RX_TRIG_00 = 7'h08;
  localparam logic [6:0] RX_TRIG_01 = 7'h10;
  localparam logic [6:0] RX_TRIG_10 = 7'h38;
  localparam logic [6:0] RX_TRIG_11 = 7'h3C;
  localparam logic [6:0] TX_TRIG_00 = 7'h08;
  localparam logic [6:0] TX_TRIG_01 = 7'h10;
  localparam logic [6:0] TX_TRIG_10 = 7'h20;
  localparam logic [6:0] TX_TRIG_11 = 7'h38;
  localparam logic [6:0] TRIG_ONE = 7'h01;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;

  // Raw event levels from the serial datapath.
  typedef struct packed {
    logic line_err;
    logic rx_timeout;
    logic modem_delta;
    logic cts_dsr_chg;
    logic rts_dtr_chg;
    logic xoff_char;
    logic gpio_chg;
  } int_src_s;

  // Enabled requests, one per priority slot.
  typedef struct packed {
    logic line;
    logic rx_timeout;
    logic rx_ready;
    logic tx_ready;
    logic modem;
    logic gpio;
    logic xoff;
    logic flow;
  } int_req_s;

endpackage

// ### verilog/uart_int_fifo_ctl.sv
// Interrupt, FIFO trigger, sleep and divisor control of the UART bridge.
//
// Notes on behaviour
// - Divisor bytes set to 01/00 only by power-on reset.
// - Enable bit 7: CTS/DSR change interrupt.
// - Enable bit 6: RTS/DTR change interrupt.
// - Enable bit 5: Xoff/special character interrupt.
// - Sleep only when idle, quiet, empty, enabled.
// - Wake on modem toggle, RX low, TX load.
// - Sleep stops oscillator and UART clock.
// - Bits 3, 2 gate modem and line status.
// - Transmit ready: holding empty or spaces above trigger.
// - Upper enable bits writable only when enhanced.
// - Identification bit 0 high means none pending.
// - Line error, timeout, receive ready codes.
// - Transmit ready, modem, GPIO change codes.
// - Xoff/special and flow inactive codes.
// - Receive trigger 8, 16, 56, 60.
// - Transmit trigger 8, 16, 32, 56 spaces.
// - Transmit FIFO clear, self-clearing bit.
// - Receive FIFO clear, self-clearing bit.
// - FIFO disabled: one character, trigger one.
// - Transmit trigger writable only when enhanced.
// - Enhanced bit unlocks upper fields and sleep.
module uart_int_fifo_ctl #(
  parameter logic [6:0] FIFO_ENTRIES = uart_ifc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire uart_ifc_pkg::int_src_s int_src,
  input wire logic [6:0] rx_count,
  input wire logic [6:0] tx_count,
  input wire logic modem_toggle,
  input wire logic rx_pin,
  output logic irq_pending,
  output logic [7:0] div_low,
  output logic [7:0] div_high,
  output logic fifo_en,
  output logic tx_fifo_clear,
  output logic rx_fifo_clear,
  output logic tx_load,
  output logic [7:0] tx_byte,
  output logic osc_stop
);
  import uart_ifc_pkg::*;

  typedef struct packed {
    logic [7:0] line_control_reg;
    logic [7:0] interrupt_enable;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic fifo_en;
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic [7:0] interrupt_identification;
    logic [7:0] rdata;
    logic tx_clr;
    logic rx_clr;
    logic tx_load;
    logic [7:0] tx_byte;
    logic sleep;
  } ctl_s;

  localparam ctl_s CTL_RST = '{
    line_control_reg: LCR_RST,
    interrupt_enable: IER_RST,
    enhanced_feature_reg: EFR_RST,
    div_low: DIV_LOW_RST,
    div_high: DIV_HIGH_RST,
    fifo_en: 1'b0,
    rx_trig: 2'h0,
    tx_trig: 2'h0,
    interrupt_identification: IIR_RST,
    rdata: 8'h00,
    tx_clr: 1'b0,
    rx_clr: 1'b0,
    tx_load: 1'b0,
    tx_byte: 8'h00,
    sleep: 1'b0
  };

  ctl_s st_r;
  ctl_s st_nxt;
  int_req_s req;
  logic [5:0] iid;
  logic enh;
  logic div_bank;
  logic enh_bank;
  logic [6:0] rx_level;
  logic [6:0] tx_level;
  logic [6:0] tx_free;
  logic rx_ready_lvl;
  logic tx_ready_lvl;
  logic hold_wr;
  logic sleep_ok;
  logic wake;

  assign enh = st_r.enhanced_feature_reg[EFR_ENH];
  assign div_bank = st_r.line_control_reg[LCR_DIV_BIT];
  assign enh_bank = (st_r.line_control_reg == LCR_ENH_KEY);
  assign tx_free = FIFO_ENTRIES - tx_count;

  // Trigger thresholds follow the stored codes only while FIFOs run.
  always_comb begin
    rx_level = TRIG_ONE;
    tx_level = TRIG_ONE;
    // FIFO off means trigger of one.
    if (st_r.fifo_en) begin
      unique case (st_r.rx_trig)
        2'h0: rx_level = RX_TRIG_00;
        2'h1: rx_level = RX_TRIG_01;
        2'h2: rx_level = RX_TRIG_10;
        2'h3: rx_level = RX_TRIG_11;
      endcase
      unique case (st_r.tx_trig)
        2'h0: tx_level = TX_TRIG_00;
        2'h1: tx_level = TX_TRIG_01;
        2'h2: tx_level = TX_TRIG_10;
        2'h3: tx_level = TX_TRIG_11;
      endcase
    end
  end

  assign rx_ready_lvl = (rx_count >= rx_level);
  // Holding empty, or free spaces above trigger.
  assign tx_ready_lvl = st_r.fifo_en ? (tx_free > tx_level)
                                     : (tx_count == 7'h00);

  always_comb begin
    // Line status and modem gated by bits 2, 3.
    req.line = st_r.interrupt_enable[IER_LINE] && int_src.line_err;
    req.modem = st_r.interrupt_enable[IER_MODEM] && int_src.modem_delta;
    // The receive timeout shares the receive data enable.
    req.rx_timeout = st_r.interrupt_enable[IER_RXRDY] && int_src.rx_timeout;
    req.rx_ready = st_r.interrupt_enable[IER_RXRDY] && rx_ready_lvl;
    req.tx_ready = st_r.interrupt_enable[IER_TXRDY] && tx_ready_lvl;
    req.gpio = int_src.gpio_chg;
    req.xoff = st_r.interrupt_enable[IER_XOFF] && int_src.xoff_char;
    req.flow = (st_r.interrupt_enable[IER_CTS_DSR] && int_src.cts_dsr_chg) ||
               (st_r.interrupt_enable[IER_RTS_DTR] && int_src.rts_dtr_chg);
  end

  // Lower priorities in the same encoder.
  int_prio_enc u_prio (
    .req(req),
    .enh_en(enh),
    .code(iid)
  );

  assign hold_wr = reg_wr && (reg_addr == OFS_HOLD) && !div_bank;

  // All four sleep conditions plus enables.
  assign sleep_ok = st_r.interrupt_enable[IER_SLEEP] && enh && st_r.interrupt_identification[0] &&
                    !modem_toggle && rx_pin &&
                    (rx_count == 7'h00) && (tx_count == 7'h00) &&
                    !hold_wr;
  assign wake = modem_toggle || !rx_pin || hold_wr;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_clr = 1'b0;
    st_nxt.rx_clr = 1'b0;
    st_nxt.tx_load = 1'b0;
    // Bit 0 high when nothing pending.
    st_nxt.interrupt_identification = {st_r.fifo_en, st_r.fifo_en, iid[5:0]};

    if (reg_wr) begin
      unique case (reg_addr)
        OFS_HOLD: begin
          if (div_bank) begin
            st_nxt.div_low = reg_wdata;
          end else begin
            st_nxt.tx_load = 1'b1;
            st_nxt.tx_byte = reg_wdata;
          end
        end
        OFS_IER: begin
          if (div_bank) begin
            st_nxt.div_high = reg_wdata;
          end else begin
            st_nxt.interrupt_enable[3:0] = reg_wdata[3:0];
            if (enh) begin
              st_nxt.interrupt_enable[7:4] = reg_wdata[7:4];
            end
          end
        end
        OFS_IIR_FCR: begin
          if (enh_bank) begin
            st_nxt.enhanced_feature_reg = reg_wdata;
          end else begin
            st_nxt.fifo_en = reg_wdata[FCR_FIFO_EN];
            // Other fields locked with FIFO off.
            if (reg_wdata[FCR_FIFO_EN]) begin
              st_nxt.rx_trig = reg_wdata[FCR_RX_TRIG_LO +: 2];
              if (enh) begin
                st_nxt.tx_trig = reg_wdata[FCR_TX_TRIG_LO +: 2];
              end
              st_nxt.tx_clr = reg_wdata[FCR_TX_CLR];
              st_nxt.rx_clr = reg_wdata[FCR_RX_CLR];
            end
          end
        end
        OFS_LCR: begin
          st_nxt.line_control_reg = reg_wdata;
        end
        default: begin
          st_nxt.line_control_reg = st_r.line_control_reg;
        end
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        OFS_IER: begin
          st_nxt.rdata = div_bank ? st_r.div_high : st_r.interrupt_enable;
        end
        OFS_IIR_FCR: begin
          st_nxt.rdata = enh_bank ? st_r.enhanced_feature_reg : st_r.interrupt_identification;
        end
        OFS_LCR: begin
          st_nxt.rdata = st_r.line_control_reg;
        end
        // Write-only locations and unmapped offsets read as zero.
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Sleep flag drives the oscillator stop.
    if (st_r.sleep) begin
      if (wake || !enh) begin
        st_nxt.sleep = 1'b0;
      end
    end else if (sleep_ok) begin
      st_nxt.sleep = 1'b1;
    end

    // A software reset restores everything except the divisor.
    if (soft_rst) begin
      st_nxt = CTL_RST;
      st_nxt.div_low = st_r.div_low;
      st_nxt.div_high = st_r.div_high;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= CTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq_pending = !st_r.interrupt_identification[0];
  assign div_low = st_r.div_low;
  assign div_high = st_r.div_high;
  assign fifo_en = st_r.fifo_en;
  assign tx_fifo_clear = st_r.tx_clr;
  assign rx_fifo_clear = st_r.rx_clr;
  assign tx_load = st_r.tx_load;
  assign tx_byte = st_r.tx_byte;
  // The wake inputs are sampled on clk, so the clock source must keep
  // clk alive long enough for one wake sample after osc_stop rises.
  assign osc_stop = st_r.sleep;

endmodule
